// *** hw/mpes_map.svh ***
`ifndef MPES_MAP_SVH
`define MPES_MAP_SVH

// Register byte addresses
`define MPES_ADDR_CTRL 8'h00
`define MPES_ADDR_FABRIC 8'h04
`define MPES_ADDR_PAGE_QUAL 8'h08
`define MPES_ADDR_RETRY_QUAL 8'h0c
`define MPES_ADDR_THERM_QUAL 8'h10
`define MPES_ADDR_COUNT 8'h14
`define MPES_ADDR_DEBUG 8'h18

// Control fields
`define MPES_CTRL_CODE_HI 7
`define MPES_CTRL_ENABLE 8
`define MPES_FAB_SEL_HI 27
`define MPES_FAB_SEL_LO 24
`define MPES_FAB_RSP_HI 11
`define MPES_FAB_RSP_LO 9

// Qualifier fields
`define MPES_PAGE_DIR 0
`define MPES_RTY_FILTER 7
`define MPES_RTY_ID_HI 6
`define MPES_RTY_ID_LO 1
`define MPES_TEMP_TRIP_HI 10
`define MPES_TEMP_TRIP_LO 9
`define MPES_TEMP_ANY 3
`define MPES_TEMP_DIMM_HI 6
`define MPES_TEMP_DIMM_LO 4

// Event codes
`define MPES_EV_FABRIC 8'h10
`define MPES_EV_ID_DEPTH 8'h3c
`define MPES_EV_ID_WRITES 8'h3d
`define MPES_EV_ACCEPT 8'h1d
`define MPES_EV_PENDING 8'h3e
`define MPES_EV_AUTO_CLOSE 8'h15
`define MPES_EV_COLLISION 8'h18
`define MPES_EV_HIT 8'h14
`define MPES_EV_MISS 8'h13
`define MPES_EV_POLICY 8'h16
`define MPES_EV_REFRESH 8'h06
`define MPES_EV_RETRY 8'h0b
`define MPES_EV_RETRY_PUSH 8'h22
`define MPES_EV_STARVE 8'h03
`define MPES_EV_FULL 8'h02
`define MPES_EV_SCHED 8'h1c
`define MPES_EV_MODE 8'h08
`define MPES_EV_FAST_RESET 8'h0c
`define MPES_EV_THERM_DN 8'h05
`define MPES_EV_THERM_UP 8'h04

// Fabric selector values
`define MPES_FAB_RESPONSE 4'h6
`define MPES_FAB_SPARE_UNCOR 3'h7
`define MPES_FAB_NB_DEBUG 4'h7

// Reset values
`define MPES_RST_WORD 32'h0000_0000

`endif

// *** hw/mpes_pkg.sv ***
package mpes_pkg;

  typedef logic [5:0] mpes_amount_t;
  typedef logic [31:0] mpes_word_t;

  typedef enum logic [1:0] {
    below_low = 2'b00,
    between_low_and_mid = 2'b01,
    above_mid_falling = 2'b10,
    above_mid_rising = 2'b11
  } mpes_trip_t;

endpackage

// *** hw/mpes_top.sv ***
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mpes_map.svh"

module mpes_top
  import mpes_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic sparing_uncorrectable_response,
  input wire logic northbound_debug_trigger,
  input wire logic [7:0] northbound_debug_bits,
  input wire logic [5:0] id_fifo_depth,
  input wire logic [1:0] id_fifo_writes,
  input wire logic command_accepted,
  input wire logic [5:0] pending_depth,
  input wire logic auto_close,
  input wire logic page_collision,
  input wire logic page_hit,
  input wire logic page_miss,
  input wire logic closed_page_mode,
  input wire logic page_policy_change,
  input wire logic page_policy_to_closed,
  input wire logic refresh,
  input wire logic retry,
  input wire logic [5:0] retry_fabric_id,
  input wire logic retry_push,
  input wire logic retry_starved,
  input wire logic controller_full,
  input wire logic scheduler_accept,
  input wire logic scheduling_mode_change,
  input wire logic link_fast_reset,
  input wire logic thermal_cross,
  input wire logic thermal_up,
  input wire mpes_trip_t thermal_trip,
  input wire logic [2:0] thermal_dimm
);

  logic [7:0] event_code;
  logic enable;
  logic [3:0] fabric_event_select;
  logic [2:0] response_select;
  logic [7:0] page_table_qualifier;
  logic [7:0] retry_qualifier;
  logic [10:0] thermal_qualifier;
  mpes_word_t count;
  logic [7:0] debug_bits;
  mpes_amount_t inc;
  mpes_amount_t next_inc;
  logic count_wr;

  // Thermal crossing qualifier match, shared by both directions
  function automatic logic therm_match(
    input logic [10:0] qual,
    input mpes_trip_t trip,
    input logic [2:0] dimm
  );
    logic trip_ok;
    logic dimm_ok;
    trip_ok = trip == mpes_trip_t'(qual[`MPES_TEMP_TRIP_HI:`MPES_TEMP_TRIP_LO]);
    dimm_ok = qual[`MPES_TEMP_ANY] || (dimm == qual[`MPES_TEMP_DIMM_HI:`MPES_TEMP_DIMM_LO]);
    return trip_ok && dimm_ok;
  endfunction

  function automatic mpes_amount_t one(input logic b);
    return {5'h00, b};
  endfunction

  assign count_wr = wr && (addr == `MPES_ADDR_COUNT);

  // Register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      event_code <= 8'h00;
      enable <= 1'b0;
    end else if (wr && addr == `MPES_ADDR_CTRL) begin
      event_code <= wdata[`MPES_CTRL_CODE_HI:0];
      enable <= wdata[`MPES_CTRL_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fabric_event_select <= 4'h0;
      response_select <= 3'h0;
    end else if (wr && addr == `MPES_ADDR_FABRIC) begin
      fabric_event_select <= wdata[`MPES_FAB_SEL_HI:`MPES_FAB_SEL_LO];
      response_select <= wdata[`MPES_FAB_RSP_HI:`MPES_FAB_RSP_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      page_table_qualifier <= 8'h00;
      retry_qualifier <= 8'h00;
      thermal_qualifier <= 11'h000;
    end else if (wr) begin
      if (addr == `MPES_ADDR_PAGE_QUAL) begin
        page_table_qualifier <= wdata[7:0];
      end
      if (addr == `MPES_ADDR_RETRY_QUAL) begin
        retry_qualifier <= wdata[7:0];
      end
      if (addr == `MPES_ADDR_THERM_QUAL) begin
        thermal_qualifier <= wdata[10:0];
      end
    end
  end

  // Last northbound debug bits seen on a trigger
  always_ff @(posedge clk) begin
    if (srst) begin
      debug_bits <= 8'h00;
    end else if (northbound_debug_trigger) begin
      debug_bits <= northbound_debug_bits;
    end
  end

  // Per-cycle amount for the selected event
  always_comb begin
    next_inc = 6'h00;
    if (enable) begin
      case (event_code)
        `MPES_EV_FABRIC: begin
          if (fabric_event_select == `MPES_FAB_RESPONSE &&
              response_select == `MPES_FAB_SPARE_UNCOR) begin
            next_inc = one(sparing_uncorrectable_response);
          end else if (fabric_event_select == `MPES_FAB_NB_DEBUG) begin
            next_inc = one(northbound_debug_trigger);
          end
        end
        `MPES_EV_ID_DEPTH: next_inc = id_fifo_depth;
        `MPES_EV_ID_WRITES: next_inc = {4'h0, id_fifo_writes};
        `MPES_EV_ACCEPT: next_inc = one(command_accepted);
        `MPES_EV_PENDING: next_inc = pending_depth;
        `MPES_EV_AUTO_CLOSE: next_inc = one(auto_close);
        `MPES_EV_COLLISION: next_inc = one(page_collision);
        `MPES_EV_HIT: next_inc = one(page_hit && !closed_page_mode);
        `MPES_EV_MISS: next_inc = one(page_miss);
        `MPES_EV_POLICY: begin
          next_inc = one(page_policy_change &&
            (page_policy_to_closed == page_table_qualifier[`MPES_PAGE_DIR]));
        end
        `MPES_EV_REFRESH: next_inc = one(refresh);
        `MPES_EV_RETRY: begin
          next_inc = one(retry && (!retry_qualifier[`MPES_RTY_FILTER] ||
            retry_fabric_id == retry_qualifier[`MPES_RTY_ID_HI:`MPES_RTY_ID_LO]));
        end
        `MPES_EV_RETRY_PUSH: next_inc = one(retry_push);
        `MPES_EV_STARVE: next_inc = one(retry && retry_starved);
        `MPES_EV_FULL: next_inc = one(retry && controller_full);
        `MPES_EV_SCHED: next_inc = one(scheduler_accept);
        `MPES_EV_MODE: next_inc = one(scheduling_mode_change);
        `MPES_EV_FAST_RESET: next_inc = one(link_fast_reset);
        `MPES_EV_THERM_DN: begin
          next_inc = one(thermal_cross && !thermal_up &&
            therm_match(thermal_qualifier, thermal_trip, thermal_dimm));
        end
        `MPES_EV_THERM_UP: begin
          next_inc = one(thermal_cross && thermal_up &&
            therm_match(thermal_qualifier, thermal_trip, thermal_dimm));
        end
        default: next_inc = 6'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      inc <= 6'h00;
    end else begin
      inc <= next_inc;
    end
  end

  // Software load keeps the amount of the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= `MPES_RST_WORD;
    end else if (count_wr) begin
      count <= wdata + {26'h0, inc};
    end else begin
      count <= count + {26'h0, inc};
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= `MPES_RST_WORD;
    end else if (rd) begin
      case (addr)
        `MPES_ADDR_CTRL: rdata <= {23'h0, enable, event_code};
        `MPES_ADDR_FABRIC: rdata <= {4'h0, fabric_event_select, 12'h0, response_select, 9'h0};
        `MPES_ADDR_PAGE_QUAL: rdata <= {24'h0, page_table_qualifier};
        `MPES_ADDR_RETRY_QUAL: rdata <= {24'h0, retry_qualifier};
        `MPES_ADDR_THERM_QUAL: rdata <= {21'h0, thermal_qualifier};
        `MPES_ADDR_COUNT: rdata <= count;
        `MPES_ADDR_DEBUG: rdata <= {24'h0, debug_bits};
        default: rdata <= `MPES_RST_WORD;
      endcase
    end else begin
      rdata <= `MPES_RST_WORD;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_sel(logic [7:0] code);
    enable && event_code == code;
  endsequence

  sequence s_fab(logic [3:0] sel);
    s_sel(`MPES_EV_FABRIC) ##0 fabric_event_select == sel;
  endsequence


  // Fabric events
  a_sparing_uncor: assert property (s_fab(`MPES_FAB_RESPONSE) ##0
    response_select == `MPES_FAB_SPARE_UNCOR |=>
    inc == one($past(sparing_uncorrectable_response)))
    else $error("sparing response count wrong");
  a_fab_other_rsp: assert property (s_fab(`MPES_FAB_RESPONSE) ##0
    response_select != `MPES_FAB_SPARE_UNCOR |=> inc == 6'h00)
    else $error("other response subfield counted");
  a_debug_trigger: assert property (s_fab(`MPES_FAB_NB_DEBUG) |=>
    inc == one($past(northbound_debug_trigger)))
    else $error("debug trigger count wrong");
  a_debug_capture: assert property (!srst && northbound_debug_trigger |=>
    debug_bits == $past(northbound_debug_bits))
    else $error("debug bits not captured");

  // Depth and command events
  a_fifo_depth: assert property (s_sel(`MPES_EV_ID_DEPTH) |=>
    inc == $past(id_fifo_depth))
    else $error("fifo depth amount wrong");
  a_fifo_writes: assert property (s_sel(`MPES_EV_ID_WRITES) |=>
    inc == {4'h0, $past(id_fifo_writes)})
    else $error("fifo write amount wrong");
  a_cmd_accept: assert property (s_sel(`MPES_EV_ACCEPT) ##0 command_accepted |=>
    inc == 6'h01)
    else $error("accepted command missed");
  a_cmd_idle: assert property (s_sel(`MPES_EV_ACCEPT) ##0 !command_accepted |=>
    inc == 6'h00)
    else $error("idle cycle counted as accept");
  a_pending_depth: assert property (s_sel(`MPES_EV_PENDING) |=>
    inc == $past(pending_depth))
    else $error("pending depth amount wrong");

  // Page table events
  a_auto_close: assert property (s_sel(`MPES_EV_AUTO_CLOSE) |=>
    inc == one($past(auto_close)))
    else $error("auto close count wrong");
  a_page_collision: assert property (s_sel(`MPES_EV_COLLISION) ##0 page_collision |=>
    inc == 6'h01)
    else $error("collision missed");
  a_collision_idle: assert property (s_sel(`MPES_EV_COLLISION) ##0 !page_collision |=>
    inc == 6'h00)
    else $error("collision counted without event");
  a_hit_closed: assert property (s_sel(`MPES_EV_HIT) ##0 closed_page_mode |=>
    inc == 6'h00)
    else $error("hit counted in closed-page mode");
  a_hit_open: assert property (s_sel(`MPES_EV_HIT) ##0 page_hit && !closed_page_mode
    |=> inc == 6'h01)
    else $error("open-page hit missed");
  a_page_miss: assert property (s_sel(`MPES_EV_MISS) ##0 page_miss |=>
    inc == 6'h01)
    else $error("page miss missed");
  a_miss_idle: assert property (s_sel(`MPES_EV_MISS) ##0 !page_miss |=>
    inc == 6'h00)
    else $error("miss counted without event");
  a_policy_dir: assert property (s_sel(`MPES_EV_POLICY) ##0 page_policy_change &&
    page_policy_to_closed != page_table_qualifier[`MPES_PAGE_DIR] |=> inc == 6'h00)
    else $error("wrong policy direction counted");
  a_policy_match: assert property (s_sel(`MPES_EV_POLICY) ##0 page_policy_change &&
    page_policy_to_closed == page_table_qualifier[`MPES_PAGE_DIR] |=> inc == 6'h01)
    else $error("selected policy direction missed");
  a_refresh_seen: assert property (s_sel(`MPES_EV_REFRESH) |=>
    inc == one($past(refresh)))
    else $error("refresh count wrong");

  // Retry, scheduler and link events
  a_retry_filter: assert property (s_sel(`MPES_EV_RETRY) ##0 retry &&
    retry_qualifier[`MPES_RTY_FILTER] &&
    retry_fabric_id != retry_qualifier[`MPES_RTY_ID_HI:`MPES_RTY_ID_LO] |=> inc == 6'h00)
    else $error("filtered retry counted");
  a_retry_match: assert property (s_sel(`MPES_EV_RETRY) ##0 retry &&
    retry_qualifier[`MPES_RTY_FILTER] &&
    retry_fabric_id == retry_qualifier[`MPES_RTY_ID_HI:`MPES_RTY_ID_LO] |=> inc == 6'h01)
    else $error("retry to selected id missed");
  a_retry_all: assert property (s_sel(`MPES_EV_RETRY) ##0 retry &&
    !retry_qualifier[`MPES_RTY_FILTER] |=> inc == 6'h01)
    else $error("retry missed");
  a_retry_push: assert property (s_sel(`MPES_EV_RETRY_PUSH) |=>
    inc == one($past(retry_push)))
    else $error("retry push count wrong");
  a_retry_starve: assert property (s_sel(`MPES_EV_STARVE) |=>
    inc == one($past(retry) && $past(retry_starved)))
    else $error("starved retry count wrong");
  a_retry_full: assert property (s_sel(`MPES_EV_FULL) |=>
    inc == one($past(retry) && $past(controller_full)))
    else $error("full retry count wrong");
  a_sched_accept: assert property (s_sel(`MPES_EV_SCHED) |=>
    inc == one($past(scheduler_accept)))
    else $error("scheduler accept count wrong");
  a_mode_change: assert property (s_sel(`MPES_EV_MODE) |=>
    inc == one($past(scheduling_mode_change)))
    else $error("mode change count wrong");
  a_fast_reset: assert property (s_sel(`MPES_EV_FAST_RESET) |=>
    inc == one($past(link_fast_reset)))
    else $error("fast reset count wrong");

  // Thermal crossings
  a_therm_down: assert property (s_sel(`MPES_EV_THERM_DN) ##0 thermal_up |=>
    inc == 6'h00)
    else $error("upward crossing counted as down");
  a_therm_any_dn: assert property (s_sel(`MPES_EV_THERM_DN) ##0 thermal_cross &&
    !thermal_up && thermal_qualifier[`MPES_TEMP_ANY] &&
    thermal_trip == mpes_trip_t'(thermal_qualifier[`MPES_TEMP_TRIP_HI:`MPES_TEMP_TRIP_LO])
    |=> inc == 6'h01)
    else $error("downward crossing missed");
  a_therm_dimm: assert property (s_sel(`MPES_EV_THERM_DN) ##0 thermal_cross &&
    !thermal_up && !thermal_qualifier[`MPES_TEMP_ANY] &&
    thermal_dimm != thermal_qualifier[`MPES_TEMP_DIMM_HI:`MPES_TEMP_DIMM_LO] |=> inc == 6'h00)
    else $error("other DIMM counted");
  a_therm_up: assert property (s_sel(`MPES_EV_THERM_UP) ##0 thermal_cross &&
    thermal_up && thermal_qualifier[`MPES_TEMP_ANY] &&
    thermal_trip == mpes_trip_t'(thermal_qualifier[`MPES_TEMP_TRIP_HI:`MPES_TEMP_TRIP_LO])
    |=> inc == 6'h01)
    else $error("upward crossing missed");
  a_therm_up_dir: assert property (s_sel(`MPES_EV_THERM_UP) ##0 !thermal_up |=>
    inc == 6'h00)
    else $error("downward crossing counted as up");

  // Counter and read path
  a_disabled_idle: assert property (!enable |=> inc == 6'h00)
    else $error("disabled counter advanced");
  a_count_adds: assert property (!count_wr |=>
    count == $past(count) + {26'h0, $past(inc)})
    else $error("counter did not add amount");
  a_count_load: assert property (!srst && count_wr |=>
    count == $past(wdata) + {26'h0, $past(inc)})
    else $error("counter load wrong");
  a_read_count: assert property (!srst && rd && addr == `MPES_ADDR_COUNT |=>
    rdata == $past(count))
    else $error("count read back wrong");

endmodule

// *** testbench/mpes_pipe_model.sv ***
`timescale 1ns/1ps
module mpes_pipe_model
  import mpes_pkg::*;
(
  input wire logic fire,
  input wire logic [4:0] kind,
  input wire logic [5:0] amt,
  input wire logic [2:0] lvl,
  input wire logic [15:0] misc,
  output logic sparing_uncorrectable_response,
  output logic northbound_debug_trigger,
  output logic [7:0] northbound_debug_bits,
  output logic [5:0] id_fifo_depth,
  output logic [1:0] id_fifo_writes,
  output logic command_accepted,
  output logic [5:0] pending_depth,
  output logic auto_close,
  output logic page_collision,
  output logic page_hit,
  output logic page_miss,
  output logic closed_page_mode,
  output logic page_policy_change,
  output logic page_policy_to_closed,
  output logic refresh,
  output logic retry,
  output logic [5:0] retry_fabric_id,
  output logic retry_push,
  output logic retry_starved,
  output logic controller_full,
  output logic scheduler_accept,
  output logic scheduling_mode_change,
  output logic link_fast_reset,
  output logic thermal_cross,
  output logic thermal_up,
  output mpes_trip_t thermal_trip,
  output logic [2:0] thermal_dimm
);
  logic [17:0] sel;
  // One event kind active while fire is high
  assign sel = fire ? (18'h1 << kind) : 18'h0;
  assign sparing_uncorrectable_response = sel[0];
  assign northbound_debug_trigger = sel[1];
  assign northbound_debug_bits = misc[15:8];
  assign id_fifo_depth = sel[2] ? amt : 6'h0;
  assign id_fifo_writes = sel[3] ? amt[1:0] : 2'h0;
  assign command_accepted = sel[4];
  assign pending_depth = sel[5] ? amt : 6'h0;
  assign auto_close = sel[6];
  assign page_collision = sel[7];
  assign page_hit = sel[8];
  assign page_miss = sel[9];
  assign page_policy_change = sel[10];
  assign refresh = sel[11];
  assign retry = sel[12];
  assign retry_push = sel[13];
  assign scheduler_accept = sel[14];
  assign scheduling_mode_change = sel[15];
  assign link_fast_reset = sel[16];
  assign thermal_cross = sel[17];
  assign retry_starved = lvl[0];
  assign controller_full = lvl[1];
  assign closed_page_mode = lvl[2];
  assign page_policy_to_closed = misc[0];
  assign thermal_up = misc[0];
  assign thermal_trip = mpes_trip_t'(misc[2:1]);
  assign thermal_dimm = misc[5:3];
  assign retry_fabric_id = misc[11:6];
endmodule

// *** testbench/mpes_top_bench.sv ***
`timescale 1ns/1ps
module mpes_top_bench
  import mpes_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic fire = 1'b0;
  logic [4:0] kind = 5'h0;
  logic [5:0] amt = 6'h0;
  logic [2:0] lvl = 3'h0;
  logic [15:0] misc = 16'h0;
  logic sparing_uncorrectable_response, northbound_debug_trigger, command_accepted;
  logic [7:0] northbound_debug_bits;
  logic [5:0] id_fifo_depth, pending_depth, retry_fabric_id;
  logic [1:0] id_fifo_writes;
  logic auto_close, page_collision, page_hit, page_miss, closed_page_mode;
  logic page_policy_change, page_policy_to_closed, refresh, retry, retry_push;
  logic retry_starved, controller_full, scheduler_accept, scheduling_mode_change;
  logic link_fast_reset, thermal_cross, thermal_up;
  mpes_trip_t thermal_trip;
  logic [2:0] thermal_dimm;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] base = 32'h0;
  logic [1:0] tr;
  logic [7:0] pc [10] = '{8'h15, 8'h18, 8'h14, 8'h13, 8'h22, 8'h1c, 8'h08, 8'h0c, 8'h1d, 8'h06};
  logic [4:0] pk [10] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h04, 5'h0b};

  always #12.5 clk = ~clk;

  mpes_top u_mpes_top (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .sparing_uncorrectable_response, .northbound_debug_trigger, .northbound_debug_bits,
    .id_fifo_depth, .id_fifo_writes, .command_accepted, .pending_depth, .auto_close,
    .page_collision, .page_hit, .page_miss, .closed_page_mode, .page_policy_change,
    .page_policy_to_closed, .refresh, .retry, .retry_fabric_id, .retry_push, .retry_starved,
    .controller_full, .scheduler_accept, .scheduling_mode_change, .link_fast_reset,
    .thermal_cross, .thermal_up, .thermal_trip, .thermal_dimm);

  mpes_pipe_model u_mpes_pipe_model (.fire, .kind, .amt, .lvl, .misc,
    .sparing_uncorrectable_response, .northbound_debug_trigger, .northbound_debug_bits,
    .id_fifo_depth, .id_fifo_writes, .command_accepted, .pending_depth, .auto_close,
    .page_collision, .page_hit, .page_miss, .closed_page_mode, .page_policy_change,
    .page_policy_to_closed, .refresh, .retry, .retry_fabric_id, .retry_push, .retry_starved,
    .controller_full, .scheduler_accept, .scheduling_mode_change, .link_fast_reset,
    .thermal_cross, .thermal_up, .thermal_trip, .thermal_dimm);

  task automatic final_report();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
    @(posedge clk);
    #1 check(rdata, 32'h0);
  endtask

  // Program code and qualifier, fire the event for three cycles, read the total
  task automatic run(input logic [7:0] code, input logic [7:0] qa, input logic [31:0] qv,
                     input logic [4:0] k, input logic [5:0] a, input logic [2:0] lv,
                     input logic [15:0] m, input logic [31:0] exp);
    wr_reg(8'h00, 32'h0);
    wr_reg(qa, qv);
    wr_reg(8'h14, base);
    wr_reg(8'h00, {23'h0, 1'b1, code});
    kind <= k;
    amt <= a;
    lvl <= lv;
    misc <= m;
    fire <= 1'b1;
    repeat (3) @(posedge clk);
    fire <= 1'b0;
    lvl <= 3'h0;
    repeat (3) @(posedge clk);
    rd_chk(8'h14, exp);
    $display("case code %h kind %h done", code, k);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h1c, 32'h0);
    run(8'h06, 8'h08, 32'h0, 5'h07, 6'h0, 3'h0, 16'h0, 32'h0);
    for (int i = 0; i < 10; i++) begin
      run(pc[i], 8'h08, 32'h0, pk[i],
          6'h0, 3'h0, 16'h0, 32'h3);
    end
    base = 32'hffff_fffe;
    run(8'h06, 8'h08, 32'h0, 5'h0b, 6'h0, 3'h0, 16'h0, 32'h1);
    base = 32'h0;
    run(8'h3c, 8'h08, 32'h0, 5'h02, 6'h20, 3'h0, 16'h0, 32'h60);
    run(8'h3c, 8'h08, 32'h0, 5'h05, 6'h20, 3'h0, 16'h0, 32'h0);
    run(8'h3d, 8'h08, 32'h0, 5'h03, 6'h02, 3'h0, 16'h0, 32'h6);
    run(8'h3e, 8'h08, 32'h0, 5'h05, 6'h20, 3'h0, 16'h0, 32'h60);
    run(8'h14, 8'h08, 32'h0, 5'h08, 6'h0, 3'h4, 16'h0, 32'h0);
    run(8'h16, 8'h08, 32'h1, 5'h0a, 6'h0, 3'h0, 16'h1, 32'h3);
    run(8'h16, 8'h08, 32'h0, 5'h0a, 6'h0, 3'h0, 16'h1, 32'h0);
    run(8'h16, 8'h08, 32'h0, 5'h0a, 6'h0, 3'h0, 16'h0, 32'h3);
    run(8'h0b, 8'h0c, 32'h0, 5'h0c, 6'h0, 3'h0, 16'h0140, 32'h3);
    run(8'h0b, 8'h0c, 32'h8a, 5'h0c, 6'h0, 3'h0, 16'h0140, 32'h3);
    run(8'h0b, 8'h0c, 32'h8a, 5'h0c, 6'h0, 3'h0, 16'h0180, 32'h0);
    run(8'h03, 8'h08, 32'h0, 5'h0c, 6'h0, 3'h1, 16'h0, 32'h3);
    run(8'h03, 8'h08, 32'h0, 5'h0c, 6'h0, 3'h2, 16'h0, 32'h0);
    run(8'h02, 8'h08, 32'h0, 5'h0c, 6'h0, 3'h2, 16'h0, 32'h3);
    run(8'h02, 8'h08, 32'h0, 5'h0c, 6'h0, 3'h1, 16'h0, 32'h0);
    for (int t = 0; t < 4; t++) begin
      tr = t[1:0];
      run(8'h05, 8'h10, {21'h0, tr, 9'h008}, 5'h11, 6'h0, 3'h0,
          {13'h0, tr, 1'b0}, 32'h3);
      run(8'h04, 8'h10, {21'h0, tr, 9'h008}, 5'h11, 6'h0, 3'h0,
          {13'h0, tr, 1'b1}, 32'h3);
    end
    run(8'h05, 8'h10, 32'h608, 5'h11, 6'h0, 3'h0, 16'h7, 32'h0);
    run(8'h05, 8'h10, 32'h608, 5'h11, 6'h0, 3'h0, 16'h4, 32'h0);
    run(8'h05, 8'h10, 32'h220, 5'h11, 6'h0, 3'h0, 16'h12, 32'h3);
    run(8'h04, 8'h10, 32'h220, 5'h11, 6'h0, 3'h0, 16'h1b, 32'h0);
    run(8'h10, 8'h04, 32'h0600_0e00, 5'h00, 6'h0, 3'h0, 16'h0, 32'h3);
    run(8'h10, 8'h04, 32'h0600_0a00, 5'h00, 6'h0, 3'h0, 16'h0, 32'h0);
    run(8'h10, 8'h04, 32'h0700_0000, 5'h01, 6'h0, 3'h0, 16'ha500, 32'h3);
    rd_chk(8'h18, 32'h0000_00a5);
    rd_chk(8'h00, 32'h0000_0110);
    rd_chk(8'h04, 32'h0700_0000);
    rd_chk(8'h08, 32'h0000_0000);
    rd_chk(8'h0c, 32'h0000_008a);
    rd_chk(8'h10, 32'h0000_0220);
    // Mid-run reset clears the count and the selection
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h00, 32'h0);
    $display("case reset done");
    final_report();
  end
endmodule
